// >>> dsph_top.sv
// Purpose: sleep outputs, deep sleep warn/ack handshake and exit holdoff
// Assumes: sleep requests come from the power sequencer as levels
// Notes: suspend clock passes straight through; it is not retimed
`timescale 1ns/100ps
module dsph_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rtc_clk,
  input wire logic soft_off_req,
  input wire logic sleep_req,
  input wire logic deep_sleep_en,
  input wire logic deep_sleep_req,
  input wire logic wake_event,
  input wire logic engine_pd_ok,
  input wire logic espi_enabled,
  input wire logic suspend_ack_in_n,
  input wire logic sleep_exit_holdoff_n,
  output logic soft_off_plane_ctl_n,
  output logic active_sleep_ctl_n,
  output logic deep_sleep_state_n,
  output logic suspend_warn_out_n,
  output logic suspend_rtc_clk_out,
  output logic wake_accepted,
  output logic sleep_exit_done
);
  import dsph_pkg::*;

  dsph_sync_if sif ();
  dsph_state_t state;
  dsph_state_t next_state;
  logic ack_matches;
  logic wake_pending;
  logic holdoff_active;
  logic warn_level;
  logic pd_ack;

  // awake means the active sleep well is powered: fully on, or waiting out the holdoff
  function automatic logic dsph_awake(input dsph_state_t st);
    return (st == dsph_st_on) || (st == dsph_st_holdoff);
  endfunction : dsph_awake

  assign sif.ack_raw_n = suspend_ack_in_n;
  assign sif.holdoff_raw_n = sleep_exit_holdoff_n;

  dsph_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .s(sif)
  );

  // acknowledge agrees with the warning level the pin currently shows
  assign ack_matches = (sif.ack_n == suspend_warn_out_n);
  // RULE14 holdoff masked under espi
  assign holdoff_active = !sif.holdoff_n && !espi_enabled;

  // wakes are remembered, only honoured once the handshake allows
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_pending <= DSPH_RESET_LOW;
    end else if (state == dsph_st_on) begin
      wake_pending <= DSPH_RESET_LOW;
    end else if (wake_event) begin
      wake_pending <= DSPH_RESET_HIGH;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      dsph_st_on: begin
        if (sleep_req || soft_off_req) begin
          next_state = dsph_st_sleep;
        end
      end
      dsph_st_sleep: begin
        if (wake_pending) begin
          next_state = dsph_st_holdoff;
        end else if (deep_sleep_en && deep_sleep_req) begin
          next_state = dsph_st_warn_enter;
        end
      end
      // RULE8 no wake before ack
      dsph_st_warn_enter: begin
        if (ack_matches) begin
          next_state = wake_pending ? dsph_st_warn_exit : dsph_st_deep;
        end
      end
      dsph_st_deep: begin
        if (wake_pending) begin
          next_state = dsph_st_warn_exit;
        end
      end
      dsph_st_warn_exit: begin
        if (ack_matches) begin
          next_state = dsph_st_holdoff;
        end
      end
      // RULE13 hold exit while asserted
      dsph_st_holdoff: begin
        if (!holdoff_active) begin
          next_state = dsph_st_on;
        end
      end
      default: next_state = dsph_st_on;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= dsph_st_on;
    end else begin
      state <= next_state;
    end
  end

  // one-cycle pulses marking the accepted wake and the end of holdoff
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_accepted <= DSPH_RESET_LOW;
      sleep_exit_done <= DSPH_RESET_LOW;
    end else begin
      wake_accepted <= (state != dsph_st_holdoff) && (next_state == dsph_st_holdoff);
      sleep_exit_done <= (state == dsph_st_holdoff) && (next_state == dsph_st_on);
    end
  end

  // RULE1 soft-off plane low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soft_off_plane_ctl_n <= DSPH_RESET_HIGH;
    end else if (dsph_awake(next_state)) begin
      soft_off_plane_ctl_n <= DSPH_RESET_HIGH;
    end else if (soft_off_req) begin
      soft_off_plane_ctl_n <= DSPH_RESET_LOW;
    end
  end

  // RULE16 active sleep well control
  // deasserted on the same edge that enters holdoff so the holdoff window follows it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_sleep_ctl_n <= DSPH_RESET_HIGH;
    end else begin
      active_sleep_ctl_n <= dsph_awake(next_state);
    end
  end

  // RULE2 deep sleep low
  // RULE3 high on exit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deep_sleep_state_n <= DSPH_RESET_HIGH;
    end else begin
      deep_sleep_state_n <= (next_state != dsph_st_deep);
    end
  end

  // RULE4 warn low before deep
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_level <= DSPH_RESET_HIGH;
    end else if (next_state == dsph_st_warn_enter || next_state == dsph_st_deep) begin
      warn_level <= DSPH_RESET_LOW;
    end else begin
      warn_level <= DSPH_RESET_HIGH;
    end
  end

  // RULE12 power-down ack
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_ack <= DSPH_RESET_LOW;
    end else begin
      pd_ack <= engine_pd_ok;
    end
  end

  // RULE11 shared pin
  // deep sleep platforms never need the power-down acknowledge
  assign suspend_warn_out_n = deep_sleep_en ? warn_level : pd_ack;

  // RULE15 buffered rtc clock
  // retiming through clk would distort a clock, so it passes through
  assign suspend_rtc_clk_out = rtc_clk;
endmodule : dsph_top

// >>> dsph_pkg.sv
// Purpose: constants and types for the deep sleep power handshake block
// Assumes: one 100 MHz clock, resume-well reset active low
// Notes: no software registers; control arrives on plain ports
// Overview of operation
// RULE1 - drive soft-off plane control low while in soft-off state
// RULE2 - drive deep-sleep indication low while in deep-sleep state
// RULE3 - drive deep-sleep indication high on deep-sleep exit
// RULE4 - drive suspend warning low before entering deep sleep
// RULE5 - controller prepares for suspend power loss on warning fall
// RULE6 - controller prepares for primary activity on warning rise
// RULE7 - controller makes acknowledge match warning once prepared
// RULE8 - ignore wake events while warning asserted and acknowledge not
// RULE9 - platform may tie acknowledge straight to warning
// RULE10 - acknowledge need only follow warning when deep sleep supported
// RULE11 - warning and power-down acknowledge share one pin
// RULE12 - drive power-down acknowledge high when engine frees primary well
// RULE13 - after active-sleep control deasserts, hold exit while holdoff asserted
// RULE14 - ignore holdoff input when enhanced serial interface enabled
// RULE15 - suspend clock is buffered copy of rtc clock
// RULE16 - active-sleep control output powers the active sleep well
// RULE17 - synchronise acknowledge and holdoff inputs with two flops
package dsph_pkg;
  localparam int DSPH_SYNC_STAGES = 2;
  localparam int DSPH_WAKE_LATCH_BITS = 1;
  localparam logic DSPH_RESET_HIGH = 1'h1;
  localparam logic DSPH_RESET_LOW = 1'h0;
  typedef enum logic [2:0] {
    dsph_st_on,
    dsph_st_sleep,
    dsph_st_warn_enter,
    dsph_st_deep,
    dsph_st_warn_exit,
    dsph_st_holdoff
  } dsph_state_t;
endpackage : dsph_pkg

// >>> dsph_sync_if.sv
// Purpose: carries raw and synchronised handshake inputs
// Assumes: single clock domain
// Notes: raw side driven by top, clean side by the synchroniser
`timescale 1ns/100ps
interface dsph_sync_if;
  logic ack_raw_n;
  logic holdoff_raw_n;
  logic ack_n;
  logic holdoff_n;
  modport sync (input ack_raw_n, input holdoff_raw_n, output ack_n, output holdoff_n);
  modport user (output ack_raw_n, output holdoff_raw_n, input ack_n, input holdoff_n);
endinterface : dsph_sync_if

// >>> dsph_sync.sv
// Purpose: two-flop synchronisers for acknowledge and holdoff inputs
// Assumes: inputs idle high (deasserted) at reset
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module dsph_sync (
  input wire logic clk,
  input wire logic resetn,
  dsph_sync_if.sync s
);
  import dsph_pkg::*;
  logic [DSPH_SYNC_STAGES-1:0] ack_pipe;
  logic [DSPH_SYNC_STAGES-1:0] hold_pipe;
  // RULE17 two-flop sync
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_pipe <= '1;
      hold_pipe <= '1;
    end else begin
      ack_pipe <= {ack_pipe[0], s.ack_raw_n};
      hold_pipe <= {hold_pipe[0], s.holdoff_raw_n};
    end
  end
  assign s.ack_n = ack_pipe[DSPH_SYNC_STAGES-1];
  assign s.holdoff_n = hold_pipe[DSPH_SYNC_STAGES-1];
endmodule : dsph_sync

// >>> dsph_asserts.sv
// Purpose: port checker
// Assumes: one clock
// Notes: bound below
`timescale 1ns/100ps
module dsph_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rtc_clk,
  input wire logic soft_off_req,
  input wire logic deep_sleep_en,
  input wire logic deep_sleep_req,
  input wire logic engine_pd_ok,
  input wire logic espi_enabled,
  input wire logic suspend_ack_in_n,
  input wire logic sleep_exit_holdoff_n,
  input wire logic soft_off_plane_ctl_n,
  input wire logic active_sleep_ctl_n,
  input wire logic deep_sleep_state_n,
  input wire logic suspend_warn_out_n,
  input wire logic suspend_rtc_clk_out,
  input wire logic wake_accepted,
  input wire logic sleep_exit_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_OFF: assert property ($fell(soft_off_plane_ctl_n) |-> $past(soft_off_req)) else $error("off");
  AST_DEEP: assert property ($fell(deep_sleep_state_n) |->
    !$past(suspend_ack_in_n, 3) && !suspend_warn_out_n) else $error("deep");
  AST_EXIT: assert property ($rose(deep_sleep_state_n) |-> $rose(suspend_warn_out_n)) else $error("exit");
  AST_WARN: assert property ($fell(suspend_warn_out_n) && deep_sleep_en && $past(deep_sleep_en) |->
    $past(deep_sleep_req)) else $error("warn");
  AST_WAKE: assert property (wake_accepted |-> $past(suspend_ack_in_n, 3)) else $error("wake");
  AST_PDACK: assert property (!deep_sleep_en && !$past(deep_sleep_en) && $past(resetn) |->
    suspend_warn_out_n == $past(engine_pd_ok)) else $error("pd");
  AST_HOLD: assert property (sleep_exit_done |-> $past(sleep_exit_holdoff_n, 3) || espi_enabled) else $error("hold");
  AST_RTC: assert property (suspend_rtc_clk_out == rtc_clk) else $error("rtc");
  AST_ASW: assert property ($fell(deep_sleep_state_n) |-> !active_sleep_ctl_n) else $error("asw");
  cover property (wake_accepted);
  cover property (sleep_exit_done);
  cover property ($fell(deep_sleep_state_n));
endmodule : dsph_asserts
bind dsph_top dsph_asserts dsph_asserts_inst (.*);

// >>> dsph_ec_model.sv
// Purpose: controller side of the warn/ack handshake
// Assumes: ack idles high
// Notes: lag sets preparation time; tie shorts ack to warn
`timescale 1ns/100ps
module dsph_ec_model (
  input wire logic clk,
  input wire logic tie,
  input wire logic [3:0] lag,
  input wire logic warn_n,
  output logic ack_n
);
  logic ack_q = 1'h1;
  logic [3:0] cnt = 4'h0;
  always @(posedge clk) begin
    if (warn_n === ack_q) cnt <= 4'h0;
    else if (cnt >= lag) ack_q <= warn_n;
    else cnt <= cnt + 4'h1;
  end
  assign ack_n = tie ? warn_n : ack_q;
endmodule : dsph_ec_model

// >>> dsph_tb_top.sv
// Purpose: bench for dsph_top
// Assumes: 100 MHz clk
// Notes: exit pulses checked against a note queue
`timescale 1ns/100ps
module dsph_tb_top;
  logic clk, resetn, rtc_clk, soft_off_req, sleep_req, deep_sleep_en, deep_sleep_req, wake_event, tie;
  logic engine_pd_ok, espi_enabled, suspend_ack_in_n, sleep_exit_holdoff_n, soft_off_plane_ctl_n;
  logic active_sleep_ctl_n, deep_sleep_state_n, suspend_warn_out_n, suspend_rtc_clk_out, wake_accepted;
  logic sleep_exit_done;
  logic [3:0] lag;
  logic [1:0] q[$];
  int err_total, cmp_count;
  dsph_top dsph_top_inst (.*);
  dsph_ec_model dsph_ec_model_inst (.clk(clk), .tie(tie), .lag(lag), .warn_n(suspend_warn_out_n), .ack_n(suspend_ack_in_n));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always #37 rtc_clk = ~rtc_clk;
  task chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task summarize();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // bounded wait for a deep-sleep level and an empty queue
  task wt(input logic v);
    int i;
    for (i = 0; i < 80 && (deep_sleep_state_n !== v || q.size() != 0); i++) @(posedge clk);
    if (i == 80) begin
      err_total++;
      summarize();
    end
  endtask : wt
  always @(posedge clk) begin
    #1;
    if (wake_accepted === 1'h1 || sleep_exit_done === 1'h1)
      chk("pulse", {sleep_exit_done, wake_accepted}, q.size() ? q.pop_front() : 2'h0);
  end
  initial begin
    {rtc_clk, resetn, soft_off_req, sleep_req, deep_sleep_req, wake_event, engine_pd_ok, espi_enabled, tie} = 9'h0;
    {deep_sleep_en, sleep_exit_holdoff_n, lag} = 6'h30;
    void'($urandom(90));
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    deep_sleep_en <= 1'h0;
    repeat (4) begin
      engine_pd_ok <= 1'($urandom);
      repeat (3) @(posedge clk);
      chk("pdack", {1'h0, suspend_warn_out_n}, {1'h0, engine_pd_ok});
    end
    // park the shared pin high so a stale low ack cannot fake the first handshake
    engine_pd_ok <= 1'h1;
    repeat (5) @(posedge clk);
    deep_sleep_en <= 1'h1;
    // last pass masks holdoff via espi
    for (int it = 0; it < 3; it++) begin
      lag <= 4'($urandom % 8);
      tie <= (it == 1);
      espi_enabled <= (it == 2);
      {sleep_req, deep_sleep_req, sleep_exit_holdoff_n} <= 3'h6;
      wt(1'h0);
      chk("warn", {active_sleep_ctl_n, suspend_warn_out_n}, 2'h0);
      {sleep_req, deep_sleep_req, wake_event} <= 3'h1;
      q.push_back(2'h1);
      if (it == 2) q.push_back(2'h2);
      @(posedge clk);
      wake_event <= 1'h0;
      wt(1'h1);
      chk("wake", {active_sleep_ctl_n, suspend_warn_out_n}, 2'h3);
      if (it != 2) begin
        repeat (8) @(posedge clk);
        q.push_back(2'h2);
        sleep_exit_holdoff_n <= 1'h1;
        wt(1'h1);
      end
    end
    soft_off_req <= 1'h1;
    repeat (3) @(posedge clk);
    chk("soft", {soft_off_plane_ctl_n, 1'h0}, 2'h0);
    {soft_off_req, wake_event} <= 2'h1;
    q.push_back(2'h1);
    q.push_back(2'h2);
    @(posedge clk);
    wake_event <= 1'h0;
    wt(1'h1);
    chk("soft", {soft_off_plane_ctl_n, 1'h0}, 2'h2);
    summarize();
  end
endmodule : dsph_tb_top
